// ==== core/fbpe_consts.svh ====
// Offsets, status bit positions, command codes and sizes of the buffered program engine.
// Included by the package and the top module; definitions only.
`ifndef FBPE_CONSTS_SVH
`define FBPE_CONSTS_SVH
`define FBPE_OFS_ADDR 8'h00
`define FBPE_OFS_DATA 8'h04
`define FBPE_OFS_STAT 8'h08
`define FBPE_OFS_CTRL 8'h0C
`define FBPE_BUF_WORDS 32
`define FBPE_ALIGN_BITS 5
`define FBPE_ADDR_W 26
`define FBPE_BLK_LOG2 16
`define FBPE_CMD_BP_SETUP 8'hE8
`define FBPE_CMD_FB_SETUP 8'h80
`define FBPE_CMD_CONFIRM 8'hD0
`define FBPE_CMD_CLR_STAT 8'h50
`define FBPE_CMD_RD_STAT 8'h70
`define FBPE_CMD_RD_ARRAY 8'hFF
`define FBPE_PAD_WORD 16'hFFFF
`define FBPE_SR_READY 7
`define FBPE_SR_SEQ 5
`define FBPE_SR_PRG 4
`define FBPE_SR_VPP 3
`define FBPE_SR_LOCK 1
`define FBPE_SR_BUSY 0
`define FBPE_SR_RESET 8'h80
`define FBPE_SR_ERR_MASK 8'h3A
`define FBPE_RESP_OKAY 2'b00
`define FBPE_RESP_SLVERR 2'b10
`endif

// ==== core/fbpe_pkg.sv ====
// Types shared by the buffered program engine: engine states and the array word carrier.
// Assumes fbpe_consts.svh is on the include path.
`include "fbpe_consts.svh"
package fbpe_pkg;
	typedef enum logic [9:0] {
		FBPE_IDLE = 10'h001,
		FBPE_BP_COUNT = 10'h002,
		FBPE_BP_FIRST = 10'h004,
		FBPE_BP_DATA = 10'h008,
		FBPE_BP_CONFIRM = 10'h010,
		FBPE_BP_PROG = 10'h020,
		FBPE_FB_CONFIRM = 10'h040,
		FBPE_FB_SETUP = 10'h080,
		FBPE_FB_FILL = 10'h100,
		FBPE_FB_PROG = 10'h200
	} fbpe_state_t;
	// One word headed for the array
	typedef struct packed {
		logic [`FBPE_ADDR_W-1:0] addr;
		logic [15:0] data;
	} fbpe_word_t;
endpackage : fbpe_pkg

// ==== core/fbpe_top.sv ====
// Buffered and factory block-fill programming engine with an AXI4-Lite command port.
// Assumes one clock, synchronous inputs, and an array that answers each word with array_done.
`timescale 1ns/1ps
`include "fbpe_consts.svh"
module fbpe_top #(
	parameter int BLK_LOG2 = `FBPE_BLK_LOG2,
	parameter int BUF_WORDS = `FBPE_BUF_WORDS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic supply_lockout,
	input wire logic supply_high,
	input wire logic block_locked,
	output fbpe_pkg::fbpe_word_t array_word,
	output logic array_valid,
	input wire logic array_done,
	input wire logic array_err,
	output logic [`FBPE_ADDR_W-1:0] array_raddr,
	input wire logic [15:0] array_rdata
);
	import fbpe_pkg::*;

	localparam int AW = `FBPE_ADDR_W;
	localparam int IW = $clog2(BUF_WORDS);

	logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, addr_q;
	logic [3:0] wstrb_q;
	fbpe_state_t st_q;
	logic [7:0] sr_q;
	logic [IW:0] cnt_q, fill_q, idx_q;
	logic [AW-1:0] org_q, start_q, parr_q;
	logic [15:0] buf_mem [BUF_WORDS];
	logic arr_valid_q, read_status_q;
	fbpe_word_t arr_word_q;

	// Write channel handshakes and commit point
	wire aw_hs = awvalid && awready_q;
	wire w_hs = wvalid && wready_q;
	wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
	wire wr_aligned = awaddr_q[1:0] == 2'b00;
	wire wr_addr_sel = wr_aligned && awaddr_q == `FBPE_OFS_ADDR;
	wire wr_data_sel = wr_aligned && awaddr_q == `FBPE_OFS_DATA;
	wire wr_stat_sel = wr_aligned && awaddr_q == `FBPE_OFS_STAT;
	wire wr_ctrl_sel = wr_aligned && awaddr_q == `FBPE_OFS_CTRL;
	wire wr_mapped = wr_addr_sel || wr_data_sel || wr_stat_sel || wr_ctrl_sel;

	// A flash bus write needs both low byte lanes; partial writes are dropped
	wire fw_go = wr_fire && wr_data_sel && (wstrb_q[1:0] == 2'b11);
	wire [AW-1:0] fw_addr = addr_q[AW-1:0];
	wire [15:0] fw_data = wdata_q[15:0];
	wire [7:0] cmd = fw_data[7:0];
	wire clr_go = wr_fire && wr_ctrl_sel && wstrb_q[0] && wdata_q[0];

	// Read decode; data window shows status while the engine runs
	wire ar_hs = arvalid && arready_q;
	wire rd_aligned = araddr[1:0] == 2'b00;
	wire rd_addr_sel = rd_aligned && araddr == `FBPE_OFS_ADDR;
	wire rd_data_sel = rd_aligned && araddr == `FBPE_OFS_DATA;
	wire rd_stat_sel = rd_aligned && araddr == `FBPE_OFS_STAT;
	wire rd_ctrl_sel = rd_aligned && araddr == `FBPE_OFS_CTRL;
	wire engine_busy = st_q != FBPE_IDLE;
	wire show_status = engine_busy || read_status_q;
	wire [31:0] stat_word = {24'h000000, sr_q};
	wire [31:0] data_word = show_status ? stat_word : {16'h0000, array_rdata};
	wire [31:0] rd_mux = rd_addr_sel ? addr_q :
		rd_data_sel ? data_word :
		rd_stat_sel ? stat_word :
		rd_ctrl_sel ? {30'h0, read_status_q, 1'b0} : 32'h00000000;
	wire rd_mapped = rd_addr_sel || rd_data_sel || rd_stat_sel || rd_ctrl_sel;

	// Engine decode
	wire same_org_blk = fw_addr[AW-1:BLK_LOG2] == org_q[AW-1:BLK_LOG2];
	wire [AW-1:0] off_full = fw_addr - start_q;
	wire [IW:0] bp_off = off_full[IW:0];
	wire bp_in_range = (off_full < AW'(cnt_q));
	wire [BLK_LOG2:0] bp_end = {1'b0, fw_addr[BLK_LOG2-1:0]} + (BLK_LOG2+1)'(cnt_q) - (BLK_LOG2+1)'(1);
	wire bp_cross = bp_end[BLK_LOG2];
	wire count_bad = (fw_data == 16'h0000) || (fw_data > 16'(BUF_WORDS));
	wire [IW:0] prog_total = st_q == FBPE_FB_PROG ? (IW+1)'(BUF_WORDS) : cnt_q;
	wire [AW-1:0] bp_word_addr = start_q + AW'(idx_q);
	wire [AW-1:0] nx_word_addr = st_q == FBPE_FB_PROG ? parr_q : bp_word_addr;
	wire [BLK_LOG2-1:0] parr_low_inc = parr_q[BLK_LOG2-1:0] + BLK_LOG2'(1);
	wire fill_last = fill_q == (IW+1)'(BUF_WORDS - 1);

	// Buffer write port, driven by the engine decode
	wire buf_we = fw_go && ((st_q == FBPE_BP_FIRST) || (st_q == FBPE_BP_DATA && bp_in_range) ||
		(st_q == FBPE_FB_FILL && fw_addr[AW-1:BLK_LOG2] == org_q[AW-1:BLK_LOG2]));
	wire [IW-1:0] buf_wi = st_q == FBPE_BP_FIRST ? IW'(0) :
		st_q == FBPE_BP_DATA ? bp_off[IW-1:0] : fill_q[IW-1:0];

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign array_word = arr_word_q;
	assign array_valid = arr_valid_q;
	assign array_raddr = addr_q[AW-1:0];

	// Write address and data held separately, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
				awaddr_q <= awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
				awready_q <= 1'b1;
			end
			if (w_hs) begin
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
				wready_q <= 1'b1;
			end
		end
	end

	// Write response, one per committed write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `FBPE_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? `FBPE_RESP_OKAY : `FBPE_RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Flash bus address latch, per byte lane
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_addr_lane
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					addr_q[gb*8 +: 8] <= 8'h00;
				end else if (wr_fire && wr_addr_sel && wstrb_q[gb]) begin
					addr_q[gb*8 +: 8] <= wdata_q[gb*8 +: 8];
				end
			end
		end
	endgenerate

	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `FBPE_RESP_OKAY;
		end else if (ar_hs) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_mapped ? `FBPE_RESP_OKAY : `FBPE_RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Buffer storage; no reset, a buffered-program slot the host never writes in range keeps its old word and is programmed
	always_ff @(posedge aclk) begin
		if (buf_we) begin
			buf_mem[buf_wi] <= fw_data;
		end
	end

	// Write engine. Clears come first so a same-cycle set wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= FBPE_IDLE;
			sr_q <= `FBPE_SR_RESET;
			cnt_q <= '0;
			fill_q <= '0;
			idx_q <= '0;
			org_q <= '0;
			start_q <= '0;
			parr_q <= '0;
			arr_valid_q <= 1'b0;
			arr_word_q <= '0;
			read_status_q <= 1'b0;
		end else begin
			if (clr_go || (fw_go && st_q == FBPE_IDLE && cmd == `FBPE_CMD_CLR_STAT)) begin
				sr_q <= sr_q & ~`FBPE_SR_ERR_MASK;
			end
			case (st_q)
				FBPE_IDLE: begin
					if (fw_go) begin
						case (cmd)
							`FBPE_CMD_BP_SETUP: begin
								org_q <= fw_addr;
								sr_q[`FBPE_SR_READY] <= 1'b1;
								st_q <= FBPE_BP_COUNT;
							end
							`FBPE_CMD_FB_SETUP: begin
								org_q <= fw_addr;
								st_q <= FBPE_FB_CONFIRM;
							end
							`FBPE_CMD_RD_STAT: read_status_q <= 1'b1;
							`FBPE_CMD_RD_ARRAY: read_status_q <= 1'b0;
							default: ;
						endcase
					end
				end
				FBPE_BP_COUNT: begin
					if (fw_go) begin
						if (count_bad) begin
							sr_q[`FBPE_SR_READY] <= 1'b1;
							sr_q[`FBPE_SR_SEQ] <= 1'b1;
							sr_q[`FBPE_SR_PRG] <= 1'b1;
							st_q <= FBPE_IDLE;
						end else begin
							cnt_q <= fw_data[IW:0];
							st_q <= FBPE_BP_FIRST;
						end
					end
				end
				FBPE_BP_FIRST: begin
					if (fw_go) begin
						start_q <= fw_addr;
						fill_q <= (IW+1)'(1);
						if (bp_cross) begin
							sr_q[`FBPE_SR_READY] <= 1'b1;
							sr_q[`FBPE_SR_SEQ] <= 1'b1;
							sr_q[`FBPE_SR_PRG] <= 1'b1;
							st_q <= FBPE_IDLE;
						end else if (cnt_q == (IW+1)'(1)) begin
							st_q <= FBPE_BP_CONFIRM;
						end else begin
							st_q <= FBPE_BP_DATA;
						end
					end
				end
				FBPE_BP_DATA: begin
					if (fw_go) begin
						fill_q <= fill_q + (IW+1)'(1);
						if (fill_q + (IW+1)'(1) == cnt_q) begin
							st_q <= FBPE_BP_CONFIRM;
						end
					end
				end
				FBPE_BP_CONFIRM: begin
					if (fw_go) begin
						sr_q[`FBPE_SR_READY] <= 1'b1;
						if (cmd != `FBPE_CMD_CONFIRM || !same_org_blk) begin
							sr_q[`FBPE_SR_SEQ] <= 1'b1;
							sr_q[`FBPE_SR_PRG] <= 1'b1;
							st_q <= FBPE_IDLE;
						end else if (supply_lockout) begin
							sr_q[`FBPE_SR_PRG] <= 1'b1;
							sr_q[`FBPE_SR_VPP] <= 1'b1;
							st_q <= FBPE_IDLE;
						end else if (block_locked) begin
							sr_q[`FBPE_SR_PRG] <= 1'b1;
							sr_q[`FBPE_SR_LOCK] <= 1'b1;
							st_q <= FBPE_IDLE;
						end else begin
							sr_q[`FBPE_SR_READY] <= 1'b0;
							idx_q <= '0;
							st_q <= FBPE_BP_PROG;
						end
					end
				end
				FBPE_FB_CONFIRM: begin
					if (fw_go) begin
						if (cmd == `FBPE_CMD_CONFIRM) begin
							sr_q[`FBPE_SR_READY] <= 1'b0;
							st_q <= FBPE_FB_SETUP;
						end else begin
							sr_q[`FBPE_SR_READY] <= 1'b1;
							sr_q[`FBPE_SR_SEQ] <= 1'b1;
							sr_q[`FBPE_SR_PRG] <= 1'b1;
							st_q <= FBPE_IDLE;
						end
					end
				end
				FBPE_FB_SETUP: begin
					// Lock, supply and alignment checked before any data is taken
					if (block_locked || !supply_high || org_q[`FBPE_ALIGN_BITS-1:0] != '0) begin
						sr_q[`FBPE_SR_READY] <= 1'b1;
						sr_q[`FBPE_SR_PRG] <= 1'b1;
						sr_q[`FBPE_SR_LOCK] <= block_locked;
						sr_q[`FBPE_SR_VPP] <= !supply_high;
						st_q <= FBPE_IDLE;
					end else begin
						parr_q <= org_q;
						fill_q <= '0;
						sr_q[`FBPE_SR_BUSY] <= 1'b0;
						st_q <= FBPE_FB_FILL;
					end
				end
				FBPE_FB_FILL: begin
					if (fw_go) begin
						if (fw_addr[AW-1:BLK_LOG2] != org_q[AW-1:BLK_LOG2]) begin
							// Partial fill is dropped; exit keeps the read mode
							sr_q[`FBPE_SR_READY] <= 1'b1;
							st_q <= FBPE_IDLE;
						end else if (fill_last) begin
							sr_q[`FBPE_SR_BUSY] <= 1'b1;
							idx_q <= '0;
							st_q <= FBPE_FB_PROG;
						end else begin
							fill_q <= fill_q + (IW+1)'(1);
						end
					end
				end
				FBPE_BP_PROG, FBPE_FB_PROG: begin
					// Host writes are not looked at here
					if (arr_valid_q) begin
						if (array_done) begin
							arr_valid_q <= 1'b0;
							idx_q <= idx_q + (IW+1)'(1);
							parr_q <= {parr_q[AW-1:BLK_LOG2], parr_low_inc};
							if (array_err) begin
								sr_q[`FBPE_SR_READY] <= 1'b1;
								sr_q[`FBPE_SR_PRG] <= 1'b1;
								st_q <= FBPE_IDLE;
							end
						end
					end else if (idx_q == prog_total) begin
						if (st_q == FBPE_FB_PROG) begin
							fill_q <= '0;
							sr_q[`FBPE_SR_BUSY] <= 1'b0;
							st_q <= FBPE_FB_FILL;
						end else begin
							sr_q[`FBPE_SR_READY] <= 1'b1;
							read_status_q <= 1'b1;
							st_q <= FBPE_IDLE;
						end
					end else begin
						// Boundary crossings cost the array extra time, not this engine
						arr_word_q <= '{addr: nx_word_addr, data: buf_mem[idx_q[IW-1:0]]};
						arr_valid_q <= 1'b1;
					end
				end
				default: st_q <= FBPE_IDLE;
			endcase
		end
	end
endmodule : fbpe_top

// ==== verif/fbpe_top_assertions.sv ====
// Concurrent checks on the port behaviour of the buffered program engine.
// Assumes one clock domain and is bound to every fbpe_top instance.
`timescale 1ns/1ps
`include "fbpe_consts.svh"
module fbpe_top_assertions
	import fbpe_pkg::*;
#(
	parameter int BLK_LOG2 = 16,
	parameter int BUF_WORDS = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire fbpe_pkg::fbpe_word_t array_word,
	input wire logic array_valid,
	input wire logic array_done
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write halves taken with no answer pending
	sequence s_wr_take;
		awvalid && awready && wvalid && wready && !bvalid;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	// Reads answer one cycle and writes two cycles after the request, and stand until taken
	a_wr_answer: assert property (s_wr_take |-> ##2 bvalid)
		else $error("write answer missing");
	a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_rd_answer: assert property (s_rd_take |=> rvalid && !arready)
		else $error("read answer missing");
	a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_ar_blocked: assert property (rvalid |-> !arready)
		else $error("read taken while answer pends");
	// Array words stand until accepted, then leave a gap
	a_word_hold: assert property (array_valid && !array_done |=> array_valid && $stable(array_word))
		else $error("array word changed early");
	a_word_gap: assert property (array_valid && array_done |=> !array_valid)
		else $error("array word not released");
	// Reads while programming show busy status
	a_busy_status: assert property (s_rd_take ##0 (array_valid && araddr == `FBPE_OFS_DATA) |=> !rdata[7])
		else $error("busy read lacks status");
endmodule : fbpe_top_assertions
bind fbpe_top fbpe_top_assertions #(
	.BLK_LOG2(BLK_LOG2),
	.BUF_WORDS(BUF_WORDS)
) u_fbpe_top_assertions (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.array_word(array_word), .array_valid(array_valid), .array_done(array_done)
);

// ==== verif/fbpe_array_model.sv ====
// Behavioural flash array that accepts one word per answer after a random delay.
// Assumes the engine holds array_valid until array_done.
`timescale 1ns/1ps
module fbpe_array_model
	import fbpe_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire fbpe_pkg::fbpe_word_t array_word,
	input wire logic array_valid,
	input wire logic err_mode,
	input wire logic [25:0] array_raddr,
	output logic array_done,
	output logic array_err,
	output logic [15:0] array_rdata
);
	logic [15:0] mem [1024];
	logic [1:0] wait_q;
	int seed = 1;
	// Answer after the delay; error flag toggles outside answers so it is only trusted with array_done
	always @(posedge aclk) begin
		if (!aresetn) begin
			array_done <= 1'b0;
			array_err <= 1'b0;
			wait_q <= 2'd1;
		end else if (array_valid && !array_done && wait_q == 2'd0) begin
			array_done <= 1'b1;
			array_err <= err_mode;
			if (!err_mode)
				mem[array_word.addr[9:0]] <= array_word.data;
		end else begin
			array_done <= 1'b0;
			array_err <= ~array_err;
			if (array_done)
				wait_q <= 2'($random(seed));
			else if (array_valid)
				wait_q <= wait_q - 2'd1;
		end
	end
	// Erased cells read as all ones; only the low 1024 words are modelled
	initial begin
		for (int i = 0; i < 1024; i++)
			mem[i] = 16'hFFFF;
	end
	assign array_rdata = mem[array_raddr[9:0]];
endmodule : fbpe_array_model

// ==== verif/tb_fbpe_top.sv ====
// Self-checking bench for the buffered program engine over AXI4-Lite.
// Assumes a small block (BLK_LOG2 8) so the factory address wrap is reached quickly.
`timescale 1ns/1ps
`include "fbpe_consts.svh"
module tb_fbpe_top;
	import fbpe_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic supply_lockout = 1'b0;
	logic supply_high = 1'b0;
	logic block_locked = 1'b0;
	logic err_mode = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, array_valid, array_done, array_err;
	logic [1:0] bresp, rresp, rr_q, br_q;
	logic [31:0] rdata, rd_q;
	logic [25:0] array_raddr;
	logic [15:0] array_rdata;
	fbpe_word_t array_word;
	int seed = 1;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	always #50 aclk = ~aclk;
	fbpe_top #(.BLK_LOG2(8), .BUF_WORDS(32)) u_fbpe_top (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(1'b1), .supply_lockout(supply_lockout),
		.supply_high(supply_high), .block_locked(block_locked), .array_word(array_word),
		.array_valid(array_valid), .array_done(array_done), .array_err(array_err),
		.array_raddr(array_raddr), .array_rdata(array_rdata)
	);
	fbpe_array_model u_fbpe_array_model (
		.aclk(aclk), .aresetn(aresetn), .array_word(array_word), .array_valid(array_valid),
		.err_mode(err_mode), .array_raddr(array_raddr), .array_done(array_done),
		.array_err(array_err), .array_rdata(array_rdata)
	);
	// Expected status bits in the low byte, compared bits in the high byte
	function automatic logic [15:0] err_code(input int e);
		case (e)
			0: return 16'hFFB0;
			1: return 16'hFF90;
			2: return 16'h3030;
			4: return 16'h1010;
			5: return 16'h1212;
			default: return 16'h1818;
		endcase
	endfunction : err_code
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic give_verdict();
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	// Address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit aw_done = 0;
		bit w_done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		br_q = bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd_q = rdata;
		rr_q = rresp;
	endtask : axi_rd
	task automatic fd(input logic [15:0] d);
		axi_wr(`FBPE_OFS_DATA, {16'h0000, d});
	endtask : fd
	task automatic fw(input logic [25:0] a, input logic [15:0] d);
		axi_wr(`FBPE_OFS_ADDR, {6'h00, a});
		fd(d);
	endtask : fw
	// Read until a status bit reaches a level, bounded
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int k = 0;
		do begin
			axi_rd(a);
			k++;
		end while (rd_q[b] !== v && k < 3000);
		chk("poll_bit", {31'h0, v}, {31'h0, rd_q[b]});
	endtask : poll
	// Cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		logic [15:0] bexp [32];
		logic [15:0] fexp [64];
		logic [15:0] ec;
		logic [25:0] st;
		int n;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(`FBPE_OFS_STAT);
		chk("reset_status", 32'h80, rd_q);
		axi_rd(8'h10);
		chk("unmapped_resp", {30'h0, `FBPE_RESP_SLVERR}, {30'h0, rr_q});
		axi_wr(8'h10, 32'h0);
		chk("unmapped_wr", {30'h0, `FBPE_RESP_SLVERR}, {30'h0, br_q});
		// Buffered runs: full buffer, one word, random count
		for (int r = 0; r < 3; r++) begin
			n = (r == 0) ? 32 : (r == 1) ? 1 : 1 + ({$random(seed)} % 32);
			st = 26'h040 + 26'(r * 32);
			fw(st, {8'h00, `FBPE_CMD_BP_SETUP});
			axi_rd(`FBPE_OFS_STAT);
			chk("buf_free", 32'h1, {31'h0, rd_q[7]});
			fd(16'(n));
			chk("count_resp", {30'h0, `FBPE_RESP_OKAY}, {30'h0, br_q});
			for (int i = 0; i < n; i++) begin
				bexp[i] = 16'($random(seed));
				fw(st + 26'(i), bexp[i]);
			end
			fw(st, {8'h00, `FBPE_CMD_CONFIRM});
			poll(`FBPE_OFS_STAT, 7, 1'b1);
			chk("bp_status", 32'h80, rd_q);
			for (int i = 0; i < n; i++)
				chk("bp_word", {16'h0, bexp[i]}, {16'h0, u_fbpe_array_model.mem[st + 26'(i)]});
		end
		fd({8'h00, `FBPE_CMD_RD_ARRAY});
		axi_rd(`FBPE_OFS_DATA);
		chk("array_read", {16'h0, bexp[0]}, rd_q);
		fd({8'h00, `FBPE_CMD_RD_STAT});
		axi_rd(`FBPE_OFS_DATA);
		chk("status_mode", 32'h80, rd_q);
		// Wrong confirm, array failure, block crossing, low supply
		for (int e = 0; e < 4; e++) begin
			err_mode <= (e == 1);
			supply_lockout <= (e == 3);
			ec = err_code(e);
			st = (e == 2) ? 26'h0FE : 26'h0C0;
			fw(st, {8'h00, `FBPE_CMD_BP_SETUP});
			fd(16'h0004);
			for (int i = 0; i < 4; i++)
				fw(st + 26'(i), 16'($random(seed)) & 16'h0F0F);
			if (e != 2)
				fw(st, (e == 0) ? 16'h0040 : {8'h00, `FBPE_CMD_CONFIRM});
			poll(`FBPE_OFS_STAT, 7, 1'b1);
			chk("err_status", {24'h0, ec[7:0]}, {24'h0, rd_q[7:0] & ec[15:8]});
			axi_wr(`FBPE_OFS_CTRL, 32'h1);
			axi_rd(`FBPE_OFS_STAT);
			chk("cleared", 32'h80, rd_q);
		end
		// Factory fill of nine buffers into a block of eight
		err_mode <= 1'b0;
		supply_lockout <= 1'b0;
		supply_high <= 1'b1;
		fd({8'h00, `FBPE_CMD_RD_ARRAY});
		fw(26'h200, {8'h00, `FBPE_CMD_FB_SETUP});
		fd({8'h00, `FBPE_CMD_CONFIRM});
		axi_rd(`FBPE_OFS_DATA);
		chk("fb_ready", 32'h0, {31'h0, rd_q[7]});
		for (int b = 0; b < 9; b++) begin
			for (int i = 0; i < 32; i++) begin
				ec = 16'($random(seed));
				if (b == 1)
					fexp[32 + i] = ec;
				if (b == 8)
					fexp[i] = ec;
				fd(ec);
			end
			fd(16'h0000);
			poll(`FBPE_OFS_DATA, 0, 1'b0);
		end
		for (int i = 0; i < 64; i++)
			chk("fb_word", {16'h0, fexp[i]}, {16'h0, u_fbpe_array_model.mem[26'h200 + 26'(i)]});
		fw(26'h300, `FBPE_PAD_WORD);
		poll(`FBPE_OFS_STAT, 7, 1'b1);
		chk("fb_exit", 32'h80, rd_q);
		axi_rd(`FBPE_OFS_DATA);
		chk("read_mode_kept", 32'h0000FFFF, rd_q);
		// Partial fill left by a foreign address
		fw(26'h200, {8'h00, `FBPE_CMD_FB_SETUP});
		fd({8'h00, `FBPE_CMD_CONFIRM});
		for (int i = 0; i < 10; i++)
			fd(16'h1234 ^ 16'(i));
		fw(26'h300, `FBPE_PAD_WORD);
		poll(`FBPE_OFS_STAT, 7, 1'b1);
		chk("fb_discard", {16'h0, fexp[0]}, {16'h0, u_fbpe_array_model.mem[26'h200]});
		// Setup failures: unaligned start, locked block, wrong supply
		for (int e = 4; e < 7; e++) begin
			block_locked <= (e == 5);
			supply_high <= (e != 6);
			ec = err_code(e);
			fw(26'h200 + ((e == 4) ? 26'h3 : 26'h0), {8'h00, `FBPE_CMD_FB_SETUP});
			fd({8'h00, `FBPE_CMD_CONFIRM});
			poll(`FBPE_OFS_STAT, 7, 1'b1);
			chk("fb_setup_err", {24'h0, ec[7:0]}, {24'h0, rd_q[7:0] & ec[15:8]});
			fd({8'h00, `FBPE_CMD_CLR_STAT});
			axi_rd(`FBPE_OFS_STAT);
			chk("clr_cmd", 32'h80, rd_q);
		end
		give_verdict();
	end
endmodule : tb_fbpe_top
